// ---- include/counter_array_pkg.sv ----
// Package for the counter array control block: register map, fields,
// timebase codes and divider constants.
// Assumes a byte-wide special-function-register bus on the core clock.
package counter_array_pkg;

  // Register offsets on the special-function-register bus
  localparam logic [7:0] ARRAY_CONTROL_ADDR = 8'h00_D8;
  localparam logic [7:0] ARRAY_MODE_ADDR = 8'h00_D9;
  localparam logic [7:0] PWM_CONFIGURATION_ADDR = 8'h00_F7;
  localparam logic [7:0] REG_RESET = 8'h00_00;

  // array_control fields
  localparam int CTL_OVF_BIT = 7;
  localparam int CTL_RUN_BIT = 6;
  localparam int CTL_MATCH_LSB = 0;
  // array_mode fields
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_IRQ_BIT = 0;
  // pwm_configuration fields
  localparam int PWM_RELOAD_BIT = 7;
  localparam int PWM_COV_IRQ_BIT = 6;
  localparam int PWM_COV_BIT = 5;
  localparam int PWM_LEN_LSB = 0;

  localparam int NUM_MODULES = 3;
  localparam int COUNTER_WIDTH = 16;
  localparam logic [15:0] COUNTER_ALL_ONES = 16'hFFFF;
  localparam int BASE_CYCLE_BITS = 8;

  // Dividers for the timebase sources
  localparam int DIV_SYS_12 = 12;
  localparam int DIV_SYS_4 = 4;
  localparam int DIV_EXT_8 = 8;
  localparam int DIV_WIDTH = 4;

  typedef enum logic [2:0] {
    TB_SYS_DIV12 = 3'h0,
    TB_SYS_DIV4 = 3'h1,
    TB_TIMER0 = 3'h2,
    TB_EVENT = 3'h3,
    TB_SYS = 3'h4,
    TB_EXT_DIV8 = 3'h5,
    TB_LFO_DIV8 = 3'h6,
    TB_RESERVED = 3'h7
  } timebase_type;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  // Flag set events from the modules and the cycle logic
  typedef struct packed {
    logic [NUM_MODULES-1:0] match;
    logic overflow;
    logic cycle_overflow;
  } flag_set_type;

endpackage : counter_array_pkg

// ---- src/counter_array_control_regs.sv ----
// Control and status registers of the 16-bit counter array, with the
// array counter, timebase choice, sticky flags and interrupt request.
// Assumes the CPU bus gives one-cycle read/write strobes on core_clk.
`timescale 1ns/100ps
module counter_array_control_regs
  import counter_array_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  // System state
  input wire logic cpu_idle,
  // Timebase sources
  input wire logic timer0_overflow,
  input wire logic external_event_input,
  input wire logic external_clock,
  input wire logic lfo_clock,
  // Capture/compare modules
  input wire logic [NUM_MODULES-1:0] module_event,
  input wire logic [NUM_MODULES-1:0] module_irq_enable,
  // Outputs to the modules and the CPU
  output logic [COUNTER_WIDTH-1:0] array_counter,
  output logic count_tick,
  output logic reload_select,
  output logic [2:0] cycle_length,
  output logic irq
);

  // Bit stepping of the counter for the cycle length choices
  localparam logic [2:0] LEN_MAX = 3'h3;
  localparam int FLAG_COUNT = NUM_MODULES + 2;
  // Flag bank order: overflow, module flags, cycle overflow
  localparam int OVF_IDX = NUM_MODULES + 1;
  localparam int MATCH_IDX = 1;
  localparam int COV_IDX = 0;

  logic [COUNTER_WIDTH-1:0] counter_q, counter_d;
  logic run_q, run_d;
  logic idle_q, idle_d;
  logic [2:0] tb_q, tb_d;
  logic ovf_en_q, ovf_en_d;
  logic reload_q, reload_d;
  logic cov_en_q, cov_en_d;
  logic [2:0] len_q, len_d;
  logic [7:0] rdata_d;
  logic irq_d;
  logic tick_q;

  logic ctl_wr, mode_wr, pwm_wr;
  logic suspend, tick, advance, wrap, cycle_wrap;
  logic [COUNTER_WIDTH-1:0] next_count;
  flag_set_type set_ev;
  logic [FLAG_COUNT-1:0] flags;
  logic [FLAG_COUNT-1:0] flag_write;
  logic [FLAG_COUNT-1:0] flag_value;
  logic [NUM_MODULES-1:0] match_flags;
  logic ovf_flag, cov_flag;
  int unsigned cycle_bits;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase

  assign suspend = idle_q && cpu_idle;

  counter_array_timebase u_timebase (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .timebase_select(timebase_type'(tb_q)),
    .suspend(suspend),
    .timer0_overflow(timer0_overflow),
    .external_event_input(external_event_input),
    .external_clock(external_clock),
    .lfo_clock(lfo_clock),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  always_comb begin
    advance = run_q && tick && !suspend;
    next_count = counter_q + 1'b1;
    wrap = advance && (counter_q == COUNTER_ALL_ONES);
    // Chosen bit rolls over when all bits below it are ones
    cycle_bits = BASE_CYCLE_BITS + 32'(len_q > LEN_MAX ? LEN_MAX : len_q);
    cycle_wrap = advance
      && ((counter_q & ((COUNTER_WIDTH'(1) << cycle_bits) - 1'b1))
          == ((COUNTER_WIDTH'(1) << cycle_bits) - 1'b1));
    counter_d = advance ? next_count : counter_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  always_comb begin
    ctl_wr = sfr_req.wr && (sfr_req.addr == ARRAY_CONTROL_ADDR);
    mode_wr = sfr_req.wr && (sfr_req.addr == ARRAY_MODE_ADDR);
    pwm_wr = sfr_req.wr && (sfr_req.addr == PWM_CONFIGURATION_ADDR);
    run_d = ctl_wr ? sfr_req.wdata[CTL_RUN_BIT] : run_q;
    idle_d = mode_wr ? sfr_req.wdata[MODE_IDLE_BIT] : idle_q;
    tb_d = mode_wr ? sfr_req.wdata[MODE_TB_LSB +: 3] : tb_q;
    ovf_en_d = mode_wr ? sfr_req.wdata[MODE_IRQ_BIT] : ovf_en_q;
    reload_d = pwm_wr ? sfr_req.wdata[PWM_RELOAD_BIT] : reload_q;
    cov_en_d = pwm_wr ? sfr_req.wdata[PWM_COV_IRQ_BIT] : cov_en_q;
    len_d = pwm_wr ? sfr_req.wdata[PWM_LEN_LSB +: 3] : len_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags

  always_comb begin
    set_ev.match = module_event;
    set_ev.overflow = wrap;
    set_ev.cycle_overflow = cycle_wrap;
    flag_write = {ctl_wr, {NUM_MODULES{ctl_wr}}, pwm_wr};
    flag_value = {sfr_req.wdata[CTL_OVF_BIT],
                  sfr_req.wdata[CTL_MATCH_LSB +: NUM_MODULES],
                  sfr_req.wdata[PWM_COV_BIT]};
  end

  counter_array_flags #(
    .WIDTH(FLAG_COUNT)
  ) u_flags (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hw_set({set_ev.overflow, set_ev.match, set_ev.cycle_overflow}),
    .sw_write(flag_write),
    .sw_value(flag_value),
    .flags(flags)
  );

  assign ovf_flag = flags[OVF_IDX];
  assign match_flags = flags[MATCH_IDX +: NUM_MODULES];
  assign cov_flag = flags[COV_IDX];

  ////////////////////////////////////////////////////////////////////////////
  // Read data and interrupt

  always_comb begin
    rdata_d = REG_RESET;
    // Reserved bits read as zero
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        ARRAY_CONTROL_ADDR: begin
          rdata_d[CTL_OVF_BIT] = ovf_flag;
          rdata_d[CTL_RUN_BIT] = run_q;
          rdata_d[CTL_MATCH_LSB +: NUM_MODULES] = match_flags;
        end
        ARRAY_MODE_ADDR: begin
          rdata_d[MODE_IDLE_BIT] = idle_q;
          rdata_d[MODE_TB_LSB +: 3] = tb_q;
          rdata_d[MODE_IRQ_BIT] = ovf_en_q;
        end
        PWM_CONFIGURATION_ADDR: begin
          rdata_d[PWM_RELOAD_BIT] = reload_q;
          rdata_d[PWM_COV_IRQ_BIT] = cov_en_q;
          rdata_d[PWM_COV_BIT] = cov_flag;
          rdata_d[PWM_LEN_LSB +: 3] = len_q;
        end
        default: rdata_d = REG_RESET;
      endcase
    end
    irq_d = (ovf_flag && ovf_en_q)
      || |(match_flags & module_irq_enable)
      || (cov_flag && cov_en_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_q <= '0;
      run_q <= 1'b0;
      idle_q <= 1'b0;
      tb_q <= '0;
      ovf_en_q <= 1'b0;
      reload_q <= 1'b0;
      cov_en_q <= 1'b0;
      len_q <= '0;
      sfr_rdata <= REG_RESET;
      irq <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      counter_q <= counter_d;
      run_q <= run_d;
      idle_q <= idle_d;
      tb_q <= tb_d;
      ovf_en_q <= ovf_en_d;
      reload_q <= reload_d;
      cov_en_q <= cov_en_d;
      len_q <= len_d;
      sfr_rdata <= rdata_d;
      irq <= irq_d;
      tick_q <= advance;
    end
  end

  assign array_counter = counter_q;
  assign count_tick = tick_q;
  assign reload_select = reload_q;
  assign cycle_length = len_q;

endmodule : counter_array_control_regs

// ---- src/counter_array_flags.sv ----
// Sticky flag bank: hardware sets, software write of zero clears.
// A set in the same cycle as a clear wins.
`timescale 1ns/100ps
module counter_array_flags #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Controls
  input wire logic [WIDTH-1:0] hw_set,
  input wire logic [WIDTH-1:0] sw_write,
  input wire logic [WIDTH-1:0] sw_value,
  // State
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_d;

  ////////////////////////////////////////////////////////////////////////////
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
      always_comb begin
        if (hw_set[i]) begin
          flags_d[i] = 1'b1;
        end else if (sw_write[i]) begin
          flags_d[i] = sw_value[i];
        end else begin
          flags_d[i] = flags[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= flags_d;
    end
  end

endmodule : counter_array_flags

// ---- src/counter_array_timebase.sv ----
// Timebase tick generator for the counter array.
// Assumes pin inputs are already synchronous to core_clk.
`timescale 1ns/100ps
module counter_array_timebase
  import counter_array_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Source selection
  input wire timebase_type timebase_select,
  input wire logic suspend,
  // Sources
  input wire logic timer0_overflow,
  input wire logic external_event_input,
  input wire logic external_clock,
  input wire logic lfo_clock,
  // Result
  output logic tick
);

  localparam logic [DIV_WIDTH-1:0] LAST12 = DIV_WIDTH'(DIV_SYS_12 - 1);
  localparam logic [DIV_WIDTH-1:0] LAST4 = DIV_WIDTH'(DIV_SYS_4 - 1);
  localparam logic [DIV_WIDTH-1:0] LAST8 = DIV_WIDTH'(DIV_EXT_8 - 1);

  logic [DIV_WIDTH-1:0] sys_div_q, sys_div_d;
  logic [DIV_WIDTH-1:0] src_div_q, src_div_d;
  logic event_q, event_d;
  logic src_q, src_d;
  logic src_in, src_rise, event_fall;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    src_in = (timebase_select == TB_EXT_DIV8) ? external_clock : lfo_clock;
    src_rise = src_in && !src_q;
    event_fall = event_q && !external_event_input;
    event_d = external_event_input;
    src_d = src_in;
    sys_div_d = sys_div_q;
    src_div_d = src_div_q;
    tick = 1'b0;
    // Dividers hold while suspended so idle freezes the phase too
    if (!suspend) begin
      unique case (timebase_select)
        TB_SYS_DIV12: begin
          tick = (sys_div_q == LAST12);
          sys_div_d = tick ? '0 : sys_div_q + 1'b1;
        end
        TB_SYS_DIV4: begin
          tick = (sys_div_q >= LAST4);
          sys_div_d = tick ? '0 : sys_div_q + 1'b1;
        end
        TB_SYS: tick = 1'b1;
        TB_TIMER0: tick = timer0_overflow;
        TB_EVENT: tick = event_fall;
        TB_EXT_DIV8, TB_LFO_DIV8: begin
          if (src_rise) begin
            tick = (src_div_q == LAST8);
            src_div_d = tick ? '0 : src_div_q + 1'b1;
          end
        end
        TB_RESERVED: tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_div_q <= '0;
      src_div_q <= '0;
      event_q <= 1'b1;
      src_q <= 1'b0;
    end else begin
      sys_div_q <= sys_div_d;
      src_div_q <= src_div_d;
      event_q <= event_d;
      src_q <= src_d;
    end
  end

endmodule : counter_array_timebase

// ---- tb/counter_array_control_regs_checker.sv ----
// Port-level assertions for the counter array control block.
// Bound to the top module; sees only its ports, one clock domain.
`timescale 1ns/100ps
module counter_array_control_regs_checker
  import counter_array_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire sfr_req_type sfr_req,
  input wire logic [7:0] sfr_rdata,
  // Modules
  input wire logic [NUM_MODULES-1:0] module_event,
  input wire logic [NUM_MODULES-1:0] module_irq_enable,
  // Outputs
  input wire logic [COUNTER_WIDTH-1:0] array_counter,
  input wire logic reload_select,
  input wire logic [2:0] cycle_length,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic rd_ctl, rd_mode, rd_pwm, wr_pwm;
  assign rd_ctl = sfr_req.rd && sfr_req.addr == ARRAY_CONTROL_ADDR;
  assign rd_mode = sfr_req.rd && sfr_req.addr == ARRAY_MODE_ADDR;
  assign rd_pwm = sfr_req.rd && sfr_req.addr == PWM_CONFIGURATION_ADDR;
  assign wr_pwm = sfr_req.wr && sfr_req.addr == PWM_CONFIGURATION_ADDR;
  ////////////////////////////////////////////////////////////////////////
  chk_count_step: assert property (
    $changed(array_counter) |-> array_counter == $past(array_counter) + 16'h0001)
    else $error("counter moved by other than one");
  chk_ctl_reserved: assert property (
    rd_ctl |=> sfr_rdata[5:3] == 3'h0) else $error("control reserved set");
  chk_mode_reserved: assert property (
    rd_mode |=> sfr_rdata[6:4] == 3'h0) else $error("mode reserved set");
  chk_pwm_reserved: assert property (
    rd_pwm |=> sfr_rdata[4:3] == 2'h0) else $error("pwm reserved set");
  chk_reload_write: assert property (
    wr_pwm |=> reload_select == $past(sfr_req.wdata[7]))
    else $error("reload select not written");
  chk_reload_read: assert property (
    rd_pwm |=> sfr_rdata[7] == $past(reload_select))
    else $error("reload select readback wrong");
  chk_length_write: assert property (
    wr_pwm |=> cycle_length == $past(sfr_req.wdata[2:0]))
    else $error("cycle length not written");
  chk_module_irq: assert property (
    |(module_event & module_irq_enable) ##1 $stable(module_irq_enable)
    |=> irq) else $error("enabled module flag gave no irq");
  chk_irq_sticky: assert property (
    irq && !sfr_req.wr && !$past(sfr_req.wr) && $stable(module_irq_enable)
    |=> irq) else $error("irq dropped without software");
  ////////////////////////////////////////////////////////////////////////
  cover property ($rose(irq));
  cover property (array_counter == 16'hFFFF ##1 array_counter == 16'h0000);
  cover property (rd_pwm ##1 sfr_rdata[5]);
endmodule : counter_array_control_regs_checker

bind counter_array_control_regs counter_array_control_regs_checker u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .module_event(module_event),
  .module_irq_enable(module_irq_enable), .array_counter(array_counter),
  .reload_select(reload_select), .cycle_length(cycle_length), .irq(irq));

// ---- tb/test_counter_array_control_regs.sv ----
// Self-checking bench for the counter array control block.
// Drives all inputs at the falling edge; no partner model.
`timescale 1ns/100ps
module test_counter_array_control_regs
  import counter_array_pkg::*;
;
  logic core_clk, rst_n, cpu_idle, timer0_overflow, count_tick;
  logic external_event_input, external_clock, lfo_clock;
  sfr_req_type sfr_req;
  logic [7:0] sfr_rdata;
  logic [2:0] module_event, module_irq_enable, cycle_length;
  logic [15:0] array_counter;
  logic reload_select, irq;
  int bad_count = 0;
  int samples_checked = 0;

  counter_array_control_regs uut (.core_clk(core_clk), .rst_n(rst_n),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
    .timer0_overflow(timer0_overflow), .lfo_clock(lfo_clock),
    .external_event_input(external_event_input),
    .external_clock(external_clock), .module_event(module_event),
    .module_irq_enable(module_irq_enable), .array_counter(array_counter),
    .count_tick(count_tick), .reload_select(reload_select),
    .cycle_length(cycle_length), .irq(irq));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    @(negedge core_clk);
    sfr_req = {1'h1, 1'h0, a, d};
    @(negedge core_clk);
    sfr_req = '0;
  endtask : wr

  // Read data stands one cycle only, so it is taken at this negedge
  task automatic rd(input logic [7:0] a, exp);
    @(negedge core_clk);
    sfr_req = {1'h0, 1'h1, a, 8'h00_00};
    @(negedge core_clk);
    sfr_req = '0;
    check({8'h00_00, sfr_rdata}, {8'h00_00, exp});
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Every source moves in every code, so a wrong select shows up.
  // Edges stop 16 cycles early to let the edge detectors and tick register settle.
  task automatic rate(input logic [7:0] ctl, mode, input logic idle,
      input logic [15:0] exp);
    logic [15:0] start;
    logic [15:0] ticks;
    wr(ARRAY_MODE_ADDR, mode);
    wr(ARRAY_CONTROL_ADDR, ctl);
    cpu_idle = idle;
    cyc(4);
    start = array_counter;
    ticks = 16'h0000;
    for (int i = 0; i < 48; i++) begin
      timer0_overflow = i % 16 == 0 && i < 32;
      if (i < 32 && i % 4 == 0) external_event_input = ~external_event_input;
      if (i < 32) external_clock = ~external_clock;
      if (i < 32 && i % 2 == 0) lfo_clock = ~lfo_clock;
      @(negedge core_clk);
      ticks = ticks + 16'(count_tick);
    end
    check(array_counter - start, exp);
    check(ticks, exp);
    cpu_idle = 1'h0;
  endtask : rate
  ////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    rd(ARRAY_CONTROL_ADDR, REG_RESET);
    rd(ARRAY_MODE_ADDR, REG_RESET);
    rd(PWM_CONFIGURATION_ADDR, REG_RESET);
    wr(8'h00_D7, 8'h00_FF);
    rd(8'h00_D7, 8'h00_00);
    check(array_counter, 16'h0000);
  endtask : reset_values

  task automatic rate_table();
    logic [15:0] exp_t [8] = '{16'h0004, 16'h000C, 16'h0002, 16'h0004,
      16'h0030, 16'h0002, 16'h0001, 16'h0000};
    for (int c = 0; c < 8; c++)
      rate(8'h00_40, {4'h0, c[2:0], 1'h0}, 1'h0, exp_t[c]);
    rate(8'h00_00, 8'h00_08, 1'h0, 16'h0000);
    rate(8'h00_40, 8'h00_88, 1'h1, 16'h0000);
    rate(8'h00_40, 8'h00_88, 1'h0, 16'h0030);
    rate(8'h00_40, 8'h00_08, 1'h1, 16'h0030);
  endtask : rate_table

  task automatic flags_test();
    for (int m = 0; m < 3; m++) begin
      module_event[m] = 1'h1;
      cyc(1);
      module_event = 3'h0;
      cyc(3);
      check(irq, 16'h0000);
      rd(ARRAY_CONTROL_ADDR, 8'h00_40 | (8'h00_01 << m));
      module_irq_enable[m] = 1'h1;
      cyc(23);
      check(irq, 16'h0001);
      wr(ARRAY_CONTROL_ADDR, 8'h00_40);
      cyc(3);
      check(irq, 16'h0000);
      module_irq_enable = 3'h0;
    end
    cyc(1);
    // Enable already set when the event lands
    module_irq_enable = 3'h7;
    module_event = 3'h2;
    cyc(1);
    module_event = 3'h0;
    cyc(1);
    check(irq, 16'h0001);
    rd(ARRAY_CONTROL_ADDR, 8'h00_42);
    wr(ARRAY_CONTROL_ADDR, 8'h00_40);
    cyc(3);
    check(irq, 16'h0000);
    module_irq_enable = 3'h0;
  endtask : flags_test

  task automatic wrap_test();
    wr(ARRAY_MODE_ADDR, 8'h00_09);
    for (int n = 0; n < 70000 && array_counter !== 16'hFFFF; n++)
      cyc(1);
    check(irq, 16'h0000);
    cyc(3);
    check(irq, 16'h0001);
    rd(ARRAY_CONTROL_ADDR, 8'h00_C0);
    wr(ARRAY_CONTROL_ADDR, 8'h00_40);
    cyc(3);
    check(irq, 16'h0000);
  endtask : wrap_test

  task automatic pwm_test();
    wr(PWM_CONFIGURATION_ADDR, 8'h00_83);
    check({reload_select, cycle_length}, 16'h000B);
    rd(PWM_CONFIGURATION_ADDR, 8'h00_83);
    wr(PWM_CONFIGURATION_ADDR, 8'h00_40);
    cyc(300);
    rd(PWM_CONFIGURATION_ADDR, 8'h00_60);
    check(irq, 16'h0001);
    wr(PWM_CONFIGURATION_ADDR, 8'h00_02);
    cyc(1100);
    rd(PWM_CONFIGURATION_ADDR, 8'h00_22);
    check(irq, 16'h0000);
  endtask : pwm_test

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'h0;
    cpu_idle = 1'h0;
    timer0_overflow = 1'h0;
    external_event_input = 1'h1;
    external_clock = 1'h0;
    lfo_clock = 1'h0;
    sfr_req = '0;
    module_event = 3'h0;
    module_irq_enable = 3'h0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'h1;
    reset_values();
    rate_table();
    flags_test();
    wrap_test();
    pwm_test();
    close_out();
  end

  // Whole run is under 70k cycles; this allows about half again
  initial begin
    #1_000_000;
    bad_count++;
    close_out();
  end
endmodule : test_counter_array_control_regs
